// ===== bcwa_pkg.sv
// Constants, types and register map of the BCD calendar with alarms
// Contract
// - A time write restarts the second, so the next increment is one second later.
// - All time and calendar fields are BCD with tens and units digits.
// - Hours count 00 to 23 only, rolling to 00 at midnight.
// - Year wrap from 99 to 00 inverts the century bit, month bit 7.
// - Weekday advances by one at midnight; software numbers days consecutively.
// - Shadow copy of live time on each start and pointer wrap; reads use it.
// - Alarm one sits at 0Dh to 12h, alarm two at 13h to 15h.
// - Each alarm has an enable; enabled match pulls the interrupt output low.
// - Bit 7 of each alarm byte except alarm-one year, and bit 6 of alarm-one month, are masks.
// - All masks clear means every stored field must equal the current time.
// - Bit 6 of alarm day/date byte selects weekday or date comparison.
// - Alarm one masks all set fires each second; clearing adds sec, min, hour.
// - Clearing mask 4 adds date or weekday, then month, then year.
// - Alarm two fires at second 00; clearing masks adds minute, hour, day/date.
// - Enabled alarm events set status flags; reading status clears them.
// - Pointer wraps 5Dh to 00h; reaching 06h refreshes the shadow too.
// - Date rolls by month length, leap February included, through year 2199.
package bcwa_pkg;

	// Register indexes; the byte address is four times the index
	localparam logic [7:0] IDX_STATUS   = 8'h00;
	localparam logic [7:0] IDX_INT_EN   = 8'h01;
	localparam logic [7:0] IDX_SEC      = 8'h06;
	localparam logic [7:0] IDX_YEAR     = 8'h0C;
	localparam logic [7:0] IDX_ALM1_SEC = 8'h0D;
	localparam logic [7:0] IDX_ALM2_DD  = 8'h15;
	localparam logic [7:0] IDX_SNAP     = 8'h1F;

	// Positions inside the time and alarm byte arrays
	localparam int T_SEC = 0, T_MIN = 1, T_HOUR = 2, T_DAY = 3;
	localparam int T_DATE = 4, T_MON = 5, T_YEAR = 6;
	localparam int A1_SEC = 0, A1_MIN = 1, A1_HOUR = 2, A1_DD = 3;
	localparam int A1_MON = 4, A1_YEAR = 5, A2_MIN = 6, A2_HOUR = 7, A2_DD = 8;

	// Bit positions
	localparam int MASK_BIT = 7, DYDT_BIT = 6, YMASK_BIT = 6, CENT_BIT = 7;
	localparam int FLG_A1 = 0, FLG_A2 = 1;

	// BCD limits
	localparam logic [7:0] SEC_MAX   = 8'h59;
	localparam logic [7:0] HOUR_MAX  = 8'h23;
	localparam logic [7:0] DAY_MAX   = 8'h07;
	localparam logic [7:0] MON_MAX   = 8'h12;
	localparam logic [7:0] YEAR_MAX  = 8'h99;
	localparam logic [7:0] BCD_ZERO  = 8'h00;
	localparam logic [7:0] BCD_ONE   = 8'h01;

	typedef logic [6:0][7:0] bcwa_time_t;
	typedef logic [8:0][7:0] bcwa_alarm_t;

	// Reset values
	localparam bcwa_time_t  TIME_RST = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	localparam bcwa_alarm_t ALM_RST  = '0;
	localparam logic [1:0]  IEN_RST  = 2'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Time base: one second in edges of the time-base clock
	localparam int SEC_PERIOD_S     = 1;
	localparam int TB_FREQ_HZ       = 32768;
	localparam int TB_EDGES_PER_SEC = SEC_PERIOD_S * TB_FREQ_HZ;

endpackage

// ===== bcwa_time_if.sv
// Interface between register logic and the BCD calendar counter
`timescale 1ns/1ps
interface bcwa_time_if;
	logic                   tick;
	logic                   wr_en;
	logic [2:0]             wr_idx;
	logic [7:0]             wr_data;
	bcwa_pkg::bcwa_time_t   now;
	modport ctrl (output tick, output wr_en, output wr_idx, output wr_data, input now);
	modport cnt  (input tick, input wr_en, input wr_idx, input wr_data, output now);
endinterface

// ===== bcwa_counter.sv
// BCD time and calendar counter with leap-year month lengths
`timescale 1ns/1ps
module bcwa_counter
	import bcwa_pkg::*;
(
	input wire logic    aclk,
	input wire logic    aresetn,
	bcwa_time_if.cnt    tif
);

	typedef struct packed {
		bcwa_time_t t;
	} bcwa_cnt_st_t;

	bcwa_cnt_st_t s_r;
	bcwa_cnt_st_t s_nxt;
	logic [7:0]   mon_inc;

	// Two-digit BCD increment with wrap to a given first value
	function automatic logic [7:0] bcd_next(logic [7:0] v, logic [7:0] top, logic [7:0] first);
		if (v == top)
			return first;
		else if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Last date of the month; century bit set means 21xx, so 2100 is not leap
	function automatic logic [7:0] month_last(logic [7:0] mon, logic [7:0] yr);
		logic [1:0] ymod;
		logic       leap;
		ymod = {yr[4], 1'b0} + yr[1:0];
		leap = (ymod == 2'h0) && !((yr == BCD_ZERO) && mon[CENT_BIT]);
		unique case (mon[4:0])
			5'h02:   return leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// Month step without the century bit; the bit is handled on year wrap only
	assign mon_inc = bcd_next({1'b0, s_r.t[T_MON][6:0]}, MON_MAX, BCD_ONE);

	// Host write wins over a tick in the same cycle; carries ripple in one update
	always_comb
	begin
		s_nxt = s_r;
		if (tif.wr_en)
			s_nxt.t[tif.wr_idx] = tif.wr_data;
		else if (tif.tick)
		begin
			s_nxt.t[T_SEC] = bcd_next(s_r.t[T_SEC], SEC_MAX, BCD_ZERO);
			if (s_r.t[T_SEC] == SEC_MAX)
			begin
				s_nxt.t[T_MIN] = bcd_next(s_r.t[T_MIN], SEC_MAX, BCD_ZERO);
				if (s_r.t[T_MIN] == SEC_MAX)
				begin
					s_nxt.t[T_HOUR] = bcd_next(s_r.t[T_HOUR], HOUR_MAX, BCD_ZERO);
					if (s_r.t[T_HOUR] == HOUR_MAX)
					begin
						s_nxt.t[T_DAY] = bcd_next(s_r.t[T_DAY], DAY_MAX, BCD_ONE);
						s_nxt.t[T_DATE] = bcd_next(s_r.t[T_DATE],
							month_last(s_r.t[T_MON], s_r.t[T_YEAR]), BCD_ONE);
						if (s_r.t[T_DATE] == month_last(s_r.t[T_MON], s_r.t[T_YEAR]))
						begin
							s_nxt.t[T_MON][6:0] = mon_inc[6:0];
							if (s_r.t[T_MON][6:0] == MON_MAX[6:0])
							begin
								s_nxt.t[T_YEAR] = bcd_next(s_r.t[T_YEAR], YEAR_MAX, BCD_ZERO);
								if (s_r.t[T_YEAR] == YEAR_MAX)
									s_nxt.t[T_MON][CENT_BIT] = ~s_r.t[T_MON][CENT_BIT];
							end
						end
					end
				end
			end
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_r.t <= TIME_RST;
		else
			s_r <= s_nxt;
	end

	assign tif.now = s_r.t;

	// Midnight rolls hours to 00 and moves the weekday
	property p_midnight;
		@(posedge aclk) disable iff (!aresetn)
		tif.tick && !tif.wr_en && s_r.t[T_HOUR] == HOUR_MAX && s_r.t[T_MIN] == SEC_MAX
			&& s_r.t[T_SEC] == SEC_MAX
		|=> s_r.t[T_HOUR] == BCD_ZERO && s_r.t[T_DAY] != $past(s_r.t[T_DAY]);
	endproperty
	a_midnight: assert property (p_midnight) else $error("midnight rollover wrong");

	// Year wrap by counting flips the century bit; a host write of 00 over 99 does not
	property p_century;
		@(posedge aclk) disable iff (!aresetn)
		$past(tif.tick) && !$past(tif.wr_en) && s_r.t[T_YEAR] == BCD_ZERO
			&& $past(s_r.t[T_YEAR]) == YEAR_MAX
		|-> s_r.t[T_MON][CENT_BIT] != $past(s_r.t[T_MON][CENT_BIT]);
	endproperty
	a_century: assert property (p_century) else $error("century not toggled");

endmodule // bcwa_counter

// ===== bcwa_top.sv
// Register file, time base and alarm logic of the BCD calendar
`timescale 1ns/1ps
module bcwa_top
	import bcwa_pkg::*;
#(
	parameter int AXI_ADDR_W    = 10,
	parameter int TICKS_PER_SEC = TB_EDGES_PER_SEC
)
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  tb_clk,
	output logic                       irq_n
);

	localparam int IW = AXI_ADDR_W - 2;
	localparam int CW = $clog2(TICKS_PER_SEC);
	localparam logic [CW-1:0] PRE_LAST = CW'(TICKS_PER_SEC - 1);

	// Parameters the logic cannot serve
	if (AXI_ADDR_W < 9 || AXI_ADDR_W > 32)
	begin : g_bad_addr
		$error("AXI_ADDR_W must lie in 9..32");
	end
	if (TICKS_PER_SEC < 2)
	begin : g_bad_ticks
		$error("TICKS_PER_SEC must be at least 2");
	end

	typedef struct packed {
		logic                  aw_h;
		logic [IW-1:0]         aw_idx;
		logic                  w_h;
		logic [7:0]            w_d;
		logic                  w_s;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [7:0]            rdata;
		logic [1:0]            rresp;
		logic [2:0]            sync;
		logic [CW-1:0]         pre;
		logic                  tick_d;
		bcwa_alarm_t           alm;
		logic [1:0]            ien;
		logic [1:0]            flg;
		bcwa_time_t            shadow;
		logic                  irq_n;
	} bcwa_state_t;

	bcwa_state_t s_r;
	bcwa_state_t s_nxt;

	bcwa_time_if tif ();

	logic          tb_rise;
	logic          tick;
	logic          do_wr;
	logic          wr_ok;
	logic          ar_go;
	logic [IW-1:0] ar_idx;
	logic          rd_status;
	logic          refresh;
	logic          hit1;
	logic          hit2;
	logic          snap_req;
	bcwa_time_t    rd_src;

	// Index of a time register, counted from seconds
	function automatic logic is_time(logic [IW-1:0] idx);
		return idx >= IW'(IDX_SEC) && idx <= IW'(IDX_YEAR);
	endfunction

	// Index of an alarm register
	function automatic logic is_alarm(logic [IW-1:0] idx);
		return idx >= IW'(IDX_ALM1_SEC) && idx <= IW'(IDX_ALM2_DD);
	endfunction

	// Indexes answering OKAY; 02h..05h exist but hold nothing here
	function automatic logic is_mapped(logic [IW-1:0] idx);
		return idx <= IW'(IDX_ALM2_DD) || idx == IW'(IDX_SNAP);
	endfunction

	bcwa_counter u_counter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tif     (tif.cnt)
	);

	// Time base edge: the second and third synchroniser stages form the rising edge
	assign tb_rise = s_r.sync[1] && !s_r.sync[2];
	assign tick    = tb_rise && (s_r.pre == PRE_LAST);

	// Bus handshakes: one write and one read in flight
	assign s_axi_awready = !s_r.aw_h && !s_r.bvalid;
	assign s_axi_wready  = !s_r.w_h && !s_r.bvalid;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rresp   = s_r.rresp;
	assign s_axi_rdata   = {24'h000000, s_r.rdata};
	assign irq_n         = s_r.irq_n;

	assign do_wr  = s_r.aw_h && s_r.w_h;
	assign wr_ok  = do_wr && s_r.w_s && is_mapped(s_r.aw_idx);
	assign ar_go  = s_axi_arvalid && s_axi_arready;
	assign ar_idx = s_axi_araddr[AXI_ADDR_W-1:2];

	// Shadow refresh: a read of 00h stands for the pointer wrap, 06h for reaching 06h
	assign rd_status = ar_go && ar_idx == IW'(IDX_STATUS);
	assign refresh   = ar_go && (ar_idx == IW'(IDX_STATUS) || ar_idx == IW'(IDX_SEC));
	assign snap_req  = refresh || (wr_ok && s_r.aw_idx == IW'(IDX_SNAP));
	assign rd_src    = refresh ? tif.now : s_r.shadow;

	// Counter write port; a time write lands directly in the live counter
	assign tif.tick    = tick;
	assign tif.wr_en   = wr_ok && is_time(s_r.aw_idx);
	assign tif.wr_idx  = 3'(s_r.aw_idx - IW'(IDX_SEC));
	assign tif.wr_data = s_r.w_d;

	// Alarm one: each field passes when masked or equal
	always_comb
	begin
		hit1 = s_r.tick_d;
		hit1 = hit1 && (s_r.alm[A1_SEC][MASK_BIT] || s_r.alm[A1_SEC][6:0] == tif.now[T_SEC][6:0]);
		hit1 = hit1 && (s_r.alm[A1_MIN][MASK_BIT] || s_r.alm[A1_MIN][6:0] == tif.now[T_MIN][6:0]);
		hit1 = hit1 && (s_r.alm[A1_HOUR][MASK_BIT]
			|| s_r.alm[A1_HOUR][5:0] == tif.now[T_HOUR][5:0]);
		hit1 = hit1 && (s_r.alm[A1_DD][MASK_BIT] || (s_r.alm[A1_DD][DYDT_BIT]
			? s_r.alm[A1_DD][5:0] == {3'h0, tif.now[T_DAY][2:0]}
			: s_r.alm[A1_DD][5:0] == tif.now[T_DATE][5:0]));
		hit1 = hit1 && (s_r.alm[A1_MON][MASK_BIT]
			|| s_r.alm[A1_MON][4:0] == tif.now[T_MON][4:0]);
		hit1 = hit1 && (s_r.alm[A1_MON][YMASK_BIT]
			|| s_r.alm[A1_YEAR] == tif.now[T_YEAR]);
	end

	// Alarm two: no seconds field, so it only fires at second 00
	always_comb
	begin
		hit2 = s_r.tick_d && tif.now[T_SEC] == BCD_ZERO;
		hit2 = hit2 && (s_r.alm[A2_MIN][MASK_BIT] || s_r.alm[A2_MIN][6:0] == tif.now[T_MIN][6:0]);
		hit2 = hit2 && (s_r.alm[A2_HOUR][MASK_BIT]
			|| s_r.alm[A2_HOUR][5:0] == tif.now[T_HOUR][5:0]);
		hit2 = hit2 && (s_r.alm[A2_DD][MASK_BIT] || (s_r.alm[A2_DD][DYDT_BIT]
			? s_r.alm[A2_DD][5:0] == {3'h0, tif.now[T_DAY][2:0]}
			: s_r.alm[A2_DD][5:0] == tif.now[T_DATE][5:0]));
	end

	// Next state of the whole block
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sync = {s_r.sync[1:0], tb_clk};
		s_nxt.tick_d = tick;
		if (tb_rise)
			s_nxt.pre = (s_r.pre == PRE_LAST) ? '0 : s_r.pre + CW'(1);
		// Write address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_nxt.aw_h = 1'b1;
			s_nxt.aw_idx = s_axi_awaddr[AXI_ADDR_W-1:2];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_nxt.w_h = 1'b1;
			s_nxt.w_d = s_axi_wdata[7:0];
			s_nxt.w_s = s_axi_wstrb[0];
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (do_wr)
		begin
			s_nxt.aw_h = 1'b0;
			s_nxt.w_h = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = is_mapped(s_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		if (wr_ok)
		begin
			if (s_r.aw_idx == IW'(IDX_INT_EN))
				s_nxt.ien = s_r.w_d[1:0];
			if (is_alarm(s_r.aw_idx))
				s_nxt.alm[4'(s_r.aw_idx - IW'(IDX_ALM1_SEC))] = s_r.w_d;
			if (is_time(s_r.aw_idx))
				s_nxt.pre = '0;
		end
		// Read: time registers come from the shadow copy; a read of 06h takes the live time
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		if (ar_go)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			s_nxt.rdata = 8'h00;
			if (ar_idx == IW'(IDX_STATUS))
				s_nxt.rdata = {6'h00, s_r.flg};
			else if (ar_idx == IW'(IDX_INT_EN))
				s_nxt.rdata = {6'h00, s_r.ien};
			else if (is_time(ar_idx))
				s_nxt.rdata = rd_src[3'(ar_idx - IW'(IDX_SEC))];
			else if (is_alarm(ar_idx))
				s_nxt.rdata = s_r.alm[4'(ar_idx - IW'(IDX_ALM1_SEC))];
		end
		if (snap_req)
			s_nxt.shadow = tif.now;
		// Status read clears; a new hit in that cycle still sets
		if (rd_status)
			s_nxt.flg = 2'h0;
		if (hit1 && s_r.ien[FLG_A1])
			s_nxt.flg[FLG_A1] = 1'b1;
		if (hit2 && s_r.ien[FLG_A2])
			s_nxt.flg[FLG_A2] = 1'b1;
		// Registered so the pin never glitches on the compare path
		s_nxt.irq_n = ~|(s_nxt.flg & s_nxt.ien);
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.alm <= ALM_RST;
			s_r.ien <= IEN_RST;
			s_r.shadow <= TIME_RST;
			s_r.irq_n <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// A time write restarts the second count
	property p_restart;
		@(posedge aclk) disable iff (!aresetn)
		tif.wr_en |=> s_r.pre == '0 && !tick;
	endproperty
	a_restart: assert property (p_restart) else $error("second not restarted");

	// The tick lasts one cycle
	property p_tick_single;
		@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick too long");

	// Flags rise only right after a second update
	property p_flag_once;
		@(posedge aclk) disable iff (!aresetn)
		$rose(s_r.flg[FLG_A1]) || $rose(s_r.flg[FLG_A2]) |-> $past(s_r.tick_d);
	endproperty
	a_flag_once: assert property (p_flag_once) else $error("flag set off the tick");

	// Enabled alarm-one hit sets its flag and drops the interrupt
	property p_alarm_irq;
		@(posedge aclk) disable iff (!aresetn)
		hit1 && s_r.ien[FLG_A1] |=> s_r.flg[FLG_A1] && !irq_n;
	endproperty
	a_alarm_irq: assert property (p_alarm_irq) else $error("alarm did not interrupt");

	// Disabled alarm two leaves its flag alone
	property p_disabled;
		@(posedge aclk) disable iff (!aresetn)
		!s_r.ien[FLG_A2] && !s_r.flg[FLG_A2] |=> !s_r.flg[FLG_A2];
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled alarm flagged");

	// Status read without a new hit empties the flags
	property p_read_clear;
		@(posedge aclk) disable iff (!aresetn)
		rd_status && !s_r.tick_d |=> s_r.flg == 2'h0 && irq_n;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status read kept flags");

	// Alarm two flag only rises from a compare made at second 00
	property p_a2_zero;
		@(posedge aclk) disable iff (!aresetn)
		$rose(s_r.flg[FLG_A2]) |-> $past(tif.now[T_SEC]) == BCD_ZERO;
	endproperty
	a_a2_zero: assert property (p_a2_zero) else $error("alarm two off minute");

	// A flag only drops through a status read
	property p_flag_hold;
		@(posedge aclk) disable iff (!aresetn)
		$fell(s_r.flg[FLG_A1]) || $fell(s_r.flg[FLG_A2]) |-> $past(rd_status);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");

	// Alarm one flag needs its enable in the compare cycle
	property p_ien_gate;
		@(posedge aclk) disable iff (!aresetn)
		$rose(s_r.flg[FLG_A1]) |-> $past(s_r.ien[FLG_A1]);
	endproperty
	a_ien_gate: assert property (p_ien_gate) else $error("flag set while disabled");

	// Unmasked year that differs blocks alarm one
	property p_year_gate;
		@(posedge aclk) disable iff (!aresetn)
		!s_r.alm[A1_MON][YMASK_BIT] && s_r.alm[A1_YEAR] != tif.now[T_YEAR] |-> !hit1;
	endproperty
	a_year_gate: assert property (p_year_gate) else $error("year mask ignored");

	// Weekday select compares the weekday, so a differing weekday blocks alarm two
	property p_weekday_sel;
		@(posedge aclk) disable iff (!aresetn)
		s_r.alm[A2_DD][DYDT_BIT] && !s_r.alm[A2_DD][MASK_BIT]
			&& s_r.alm[A2_DD][2:0] != tif.now[T_DAY][2:0] |-> !hit2;
	endproperty
	a_weekday_sel: assert property (p_weekday_sel) else $error("day select wrong");

	// Shadow captures the live time on refresh
	property p_shadow;
		@(posedge aclk) disable iff (!aresetn)
		snap_req |=> s_r.shadow == $past(tif.now);
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow not refreshed");

	// All masks set on alarm one fires with every second
	property p_every_sec;
		@(posedge aclk) disable iff (!aresetn)
		s_r.tick_d && s_r.alm[A1_SEC][MASK_BIT] && s_r.alm[A1_MIN][MASK_BIT]
			&& s_r.alm[A1_HOUR][MASK_BIT] && s_r.alm[A1_DD][MASK_BIT]
			&& s_r.alm[A1_MON][MASK_BIT] && s_r.alm[A1_MON][YMASK_BIT] |-> hit1;
	endproperty
	a_every_sec: assert property (p_every_sec) else $error("per-second alarm missed");

	c_alarm1: cover property (@(posedge aclk) disable iff (!aresetn) hit1 && s_r.ien[FLG_A1]);
	c_alarm2: cover property (@(posedge aclk) disable iff (!aresetn) hit2 && s_r.ien[FLG_A2]);
	c_set_clr: cover property (@(posedge aclk) disable iff (!aresetn)
		rd_status && (hit1 || hit2));
	c_time_wr: cover property (@(posedge aclk) disable iff (!aresetn) tif.wr_en ##1 ar_go);

endmodule // bcwa_top

// ===== bcwa_tbase_src.sv
// Time-base oscillator model driving the slow clock input of the calendar
`timescale 1ns/1ps
module bcwa_tbase_src
#(
	parameter real HALF_NS = 40.0
)
(
	input  wire logic en,
	output logic      tb_clk
);
	// Parks low while disabled so the bench can freeze time between steps
	initial
	begin
		tb_clk = 1'b0;
		forever
		begin
			#(HALF_NS);
			tb_clk = en ? ~tb_clk : 1'b0;
		end
	end
endmodule // bcwa_tbase_src

// ===== bcd_calendar_with_alarms_tb.sv
// Testbench of the BCD calendar: register map, rollovers, alarms, reset
`timescale 1ns/1ps
module bcd_calendar_with_alarms_tb
	import bcwa_pkg::*;
;
	typedef struct packed {logic w; logic [9:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] s;}
		bcwa_row_t;
	logic        aclk, aresetn, en, tb_clk, irq_n;
	logic [9:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [1:0]  bresp, rresp, rsp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          bad_count, checked;
	// Register map rows: write or read, address, data, expected data, response
	bcwa_row_t   rows [15] = '{
		'{1'b0, 10'h000, 8'h00, 8'h00, 2'h0}, '{1'b0, 10'h004, 8'h00, 8'h00, 2'h0},
		'{1'b1, 10'h004, 8'hFF, 8'h00, 2'h0}, '{1'b0, 10'h004, 8'h00, 8'h03, 2'h0},
		'{1'b1, 10'h008, 8'h55, 8'h00, 2'h0}, '{1'b0, 10'h008, 8'h00, 8'h00, 2'h0},
		'{1'b1, 10'h034, 8'hA5, 8'h00, 2'h0}, '{1'b0, 10'h034, 8'h00, 8'hA5, 2'h0},
		'{1'b1, 10'h054, 8'h4C, 8'h00, 2'h0}, '{1'b0, 10'h054, 8'h00, 8'h4C, 2'h0},
		'{1'b1, 10'h058, 8'h11, 8'h00, 2'h2}, '{1'b0, 10'h058, 8'h00, 8'h00, 2'h2},
		'{1'b0, 10'h024, 8'h00, 8'h01, 2'h0}, '{1'b0, 10'h02C, 8'h00, 8'h01, 2'h0},
		'{1'b1, 10'h004, 8'h00, 8'h00, 2'h0}};
	// Start times and the time one second later: year,month,date,day,hour,min,sec
	bcwa_time_t  t_in [6] = '{56'h99_12_31_07_23_59_59, 56'h00_02_28_02_23_59_59,
		56'h00_82_28_02_23_59_59, 56'h23_04_30_05_23_59_59, 56'h24_02_29_07_19_59_59,
		56'h24_01_31_03_09_59_58};
	bcwa_time_t  t_ex [6] = '{56'h00_81_01_01_00_00_00, 56'h00_02_29_03_00_00_00,
		56'h00_83_01_03_00_00_00, 56'h23_05_01_06_00_00_00, 56'h24_02_29_07_20_00_00,
		56'h24_01_31_03_09_59_59};
	// Alarm one seconds match at 00, other fields masked; alarm two every minute
	logic [7:0]  alm [9] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'hC0, 8'h00, 8'h80, 8'h80, 8'h80};
	// Alarm one with every mask clear: 02:00:00 on date 01, month 01, year 00
	logic [7:0]  alm_full [6] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h01, 8'h00};

	bcwa_top #(.TICKS_PER_SEC(4)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tb_clk(tb_clk), .irq_n(irq_n));

	bcwa_tbase_src u_src (.en(en), .tb_clk(tb_clk));

	// 200 MHz bus clock
	initial
	begin
		aclk = 1'b0;
		forever
			#2.5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// A handshake that never completes ends the run as a failure
	task automatic tmo(input int n);
		if (n >= 100)
		begin
			bad_count++;
			finish_test();
		end
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		tmo(n);
	endtask

	task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		tmo(n);
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		axi_wr(a, d, rsp);
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
		axi_rd(a, got, rsp);
		chk($sformatf("reg %h", a), got, {24'h000000, e});
	endtask

	// Only calendar-consistent values are written, with the time base frozen
	task automatic set_time(input bcwa_time_t t);
		for (int i = 0; i < 7; i++)
			wr(10'(4 * (6 + i)), t[i]);
	endtask

	// Snapshot write first so every field comes from one instant
	task automatic chk_time(input bcwa_time_t t);
		wr(10'h07C, 8'h00);
		for (int i = 0; i < 7; i++)
			rd_chk(10'(4 * (6 + i)), t[i]);
	endtask

	// Six time-base rises: exactly one increment after a time write
	task automatic run_sec();
		@(posedge aclk);
		en <= 1'b1;
		repeat (90)
			@(posedge aclk);
		en <= 1'b0;
	endtask

	initial
	begin
		{aresetn, en, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		bad_count = 0;
		checked = 0;
		repeat (10)
			@(posedge aclk);
		aresetn <= 1'b1;
		// Register map, reset values, reserved and unmapped places
		foreach (rows[i])
		begin
			if (rows[i].w)
			begin
				axi_wr(rows[i].a, rows[i].d, rsp);
				chk("bresp", rsp, rows[i].s);
			end
			else
			begin
				axi_rd(rows[i].a, got, rsp);
				chk("rdata", got, rows[i].e);
				chk("rresp", rsp, rows[i].s);
			end
		end
		// Carries through every field, century flip, leap years
		foreach (t_in[i])
		begin
			set_time(t_in[i]);
			run_sec();
			chk_time(t_ex[i]);
		end
		// Alarms programmed while disabled, enabled after a second has passed
		foreach (alm[i])
			wr(10'(4 * (13 + i)), alm[i]);
		run_sec();
		wr(10'h004, 8'h03);
		set_time(56'h00_01_01_01_00_59_59);
		wr(10'h07C, 8'h00);
		run_sec();
		chk("irq_n", irq_n, 1'b0);
		rd_chk(10'h01C, 8'h59);
		rd_chk(10'h000, 8'h03);
		rd_chk(10'h01C, 8'h00);
		rd_chk(10'h000, 8'h00);
		chk("irq_n", irq_n, 1'b1);
		run_sec();
		rd_chk(10'h000, 8'h00);
		// Every-second alarm: no flag while disabled, one once enabled
		wr(10'h004, 8'h00);
		wr(10'h034, 8'h80);
		run_sec();
		rd_chk(10'h000, 8'h00);
		wr(10'h004, 8'h01);
		run_sec();
		rd_chk(10'h000, 8'h01);
		// Full match: every field compared, date selected, rewritten while disabled
		wr(10'h004, 8'h00);
		foreach (alm_full[i])
			wr(10'(4 * (13 + i)), alm_full[i]);
		run_sec();
		wr(10'h004, 8'h01);
		set_time(56'h00_01_01_01_01_59_59);
		run_sec();
		chk("irq_n", irq_n, 1'b0);
		rd_chk(10'h000, 8'h01);
		// Second reset in mid-run, with a flag pending, clears enables and the interrupt
		set_time(56'h00_01_01_01_01_59_59);
		run_sec();
		chk("irq_n", irq_n, 1'b0);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10)
			@(posedge aclk);
		aresetn <= 1'b1;
		chk("irq_n", irq_n, 1'b1);
		rd_chk(10'h004, 8'h00);
		rd_chk(10'h000, 8'h00);
		chk_time(TIME_RST);
		finish_test();
	end
endmodule // bcd_calendar_with_alarms_tb
